// ---- design/fsps_defines.vh ----
// constants of the flash self-program sequencer
`ifndef FSPS_DEFINES_VH
`define FSPS_DEFINES_VH

// ----------------------------------------
// register byte offsets on the slave bus
// ----------------------------------------
`define FSPS_OFS_CTRL 5'h00
`define FSPS_OFS_ZPTR 5'h04
`define FSPS_OFS_RDATA 5'h08
`define FSPS_OFS_INSTR 5'h0C
`define FSPS_OFS_LPM 5'h10

// ----------------------------------------
// store_program_control_reg fields
// ----------------------------------------
`define FSPS_BIT_IRQ_EN 7
`define FSPS_BIT_RW_BUSY 6
`define FSPS_BIT_REENABLE 4
`define FSPS_BIT_LOCK_SET 3
`define FSPS_BIT_PAGE_WRITE 2
`define FSPS_BIT_PAGE_ERASE 1
`define FSPS_BIT_STORE_EN 0
`define FSPS_PAT_LOAD 5'h01
`define FSPS_PAT_ERASE 5'h03
`define FSPS_PAT_WRITE 5'h05
`define FSPS_PAT_LOCK 5'h09
`define FSPS_PAT_REENABLE 5'h11
`define FSPS_SEL_LOAD 4'h0
`define FSPS_SEL_ERASE 4'h1
`define FSPS_SEL_WRITE 4'h2
`define FSPS_SEL_LOCK 4'h4
`define FSPS_SEL_REENABLE 4'h8

// ----------------------------------------
// instruction strobe register fields
// ----------------------------------------
`define FSPS_BIT_STORE_INSTR 0
`define FSPS_BIT_LOAD_INSTR 1

// ----------------------------------------
// Z pointer layout and sections
// ----------------------------------------
`define FSPS_Z_PAGE_MSB 15
`define FSPS_Z_PAGE_LSB 8
`define FSPS_Z_WORD_MSB 7
`define FSPS_Z_WORD_LSB 1
`define FSPS_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE 8'hE0
`define FSPS_Z_FUSE_LOW 16'h0000
`define FSPS_Z_LOCK 16'h0001
`define FSPS_Z_FUSE_EXT 16'h0002
`define FSPS_Z_FUSE_HIGH 16'h0003

// ----------------------------------------
// reset values
// ----------------------------------------
`define FSPS_RST_BOOT_LOCK 4'hF
`define FSPS_ERASED_WORD 16'hFFFF

// ----------------------------------------
// timing
// ----------------------------------------
`define FSPS_STORE_WINDOW 3'h4
`define FSPS_LOAD_WINDOW 2'h3
`define FSPS_CLK_PERIOD_NS 40
`define FSPS_PROG_TIME_NS 3700000
`define FSPS_PROG_CYCLES ((`FSPS_PROG_TIME_NS + `FSPS_CLK_PERIOD_NS - 1) / `FSPS_CLK_PERIOD_NS)

`endif

// ---- design/fsps_op_timer.v ----
// flash programming time counter
`timescale 1ns/1ps
`include "fsps_defines.vh"

module fsps_op_timer #(
	parameter integer CYCLES = `FSPS_PROG_CYCLES
) (
	// clock and power-on reset
	input wire clk,
	input wire por_b,
	// control
	input wire start,
	output wire busy,
	output reg done_q
);

	reg [16:0] count_q;

	// ----------------------------------------
	// count down the programming time
	// ----------------------------------------
	always @(posedge clk or negedge por_b) begin
		if (!por_b) begin
			count_q <= 17'h00000;
			done_q <= 1'b0;
		end else if (start && count_q == 17'h00000) begin
			count_q <= CYCLES[16:0];
			done_q <= 1'b0;
		end else if (count_q != 17'h00000) begin
			count_q <= count_q - 17'h00001;
			done_q <= (count_q == 17'h00001);
		end else begin
			done_q <= 1'b0;
		end
	end

	assign busy = (count_q != 17'h00000);

endmodule

// ---- design/fsps_page_buffer.v ----
// temporary page buffer: one load per word between clears
`timescale 1ns/1ps
`include "fsps_defines.vh"

module fsps_page_buffer (
	// clock and power-on reset
	input wire clk,
	input wire por_b,
	// load side
	input wire load,
	input wire [6:0] load_addr,
	input wire [15:0] load_data,
	input wire clear,
	output wire any_loaded,
	// array read side
	input wire [6:0] rd_addr,
	output reg [15:0] rd_data_q
);

	reg [15:0] mem [0:127];
	reg [127:0] loaded_q;

	// ----------------------------------------
	// per-word load flags
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 128; i = i + 1) begin : g_word
			always @(posedge clk or negedge por_b) begin
				if (!por_b) begin
					loaded_q[i] <= 1'b0;
				end else if (clear) begin
					loaded_q[i] <= 1'b0;
				end else if (load && load_addr == i[6:0]) begin
					loaded_q[i] <= 1'b1;
				end
			end
		end
	endgenerate

	// a second load to a word already held is dropped
	always @(posedge clk) begin
		if (load && !clear && !loaded_q[load_addr]) begin
			mem[load_addr] <= load_data;
		end
	end

	// unloaded words read as erased so the page stays blank there
	always @(posedge clk or negedge por_b) begin
		if (!por_b) begin
			rd_data_q <= `FSPS_ERASED_WORD;
		end else if (loaded_q[rd_addr]) begin
			rd_data_q <= mem[rd_addr];
		end else begin
			rd_data_q <= `FSPS_ERASED_WORD;
		end
	end

	assign any_loaded = |loaded_q;

endmodule

// ---- design/fsps_top.v ----
// flash self-program sequencer with its register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fsps_defines.vh"

module fsps_top #(
	parameter integer PROG_CYCLES = `FSPS_PROG_CYCLES
) (
	// clock and resets
	input wire clk,
	input wire rst_b,
	input wire por_b,
	// avalon-mm slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// pins from the rest of the chip
	input wire eeprom_write_busy,
	input wire [7:0] fuse_low_byte,
	input wire [7:0] fuse_high_byte,
	input wire [1:0] fuse_extended_bits,
	input wire [1:0] memory_lock_bits,
	// flash array side
	output reg flash_erase_start_q,
	output reg flash_write_start_q,
	output reg [7:0] flash_page_q,
	input wire [6:0] array_rd_addr,
	output wire [15:0] array_rd_data,
	// cpu side
	output wire cpu_halt,
	output wire rw_section_read_block,
	output wire program_ready_irq
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg [20:0] sync1_q;
	reg [20:0] sync2_q;
	reg ee_last_q;
	reg ack_q;
	reg irq_en_q;
	reg [3:0] sel_q;
	reg [3:0] op_sel_q;
	reg op_no_read_while_write_section_q;
	reg [2:0] store_win_q;
	reg [1:0] load_win_q;
	reg rw_busy_q;
	reg [15:0] zptr_q;
	reg [15:0] rdata_q;
	reg [7:0] lpm_result_q;
	reg [3:0] boot_lock_q;
	reg reset_clear_q;
	wire ee_busy;
	wire ee_rise;
	wire [7:0] fuse_low_s;
	wire [7:0] fuse_high_s;
	wire [1:0] fuse_ext_s;
	wire [1:0] mem_lock_s;
	wire bus_take;
	wire ctrl_wr;
	wire instr_wr;
	wire armed;
	wire op_busy;
	wire op_done;
	wire store_instr;
	wire load_instr;
	wire store_ok;
	wire load_ok;
	wire do_load;
	wire do_erase;
	wire do_write;
	wire do_lock;
	wire do_reenable;
	wire buf_any;
	wire buf_clear;
	wire store_en_rd;
	wire [4:0] pat;
	wire pat_ok;
	wire [7:0] start_page;
	wire [7:0] lock_byte;
	wire [7:0] ctrl_rd;
	reg [7:0] lpm_value;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 21'h000000;
			sync2_q <= 21'h000000;
			ee_last_q <= 1'b0;
		end else begin
			sync1_q <= {eeprom_write_busy, memory_lock_bits, fuse_extended_bits,
				fuse_high_byte, fuse_low_byte};
			sync2_q <= sync1_q;
			ee_last_q <= sync2_q[20];
		end
	end

	assign fuse_low_s = sync2_q[7:0];
	assign fuse_high_s = sync2_q[15:8];
	assign fuse_ext_s = sync2_q[17:16];
	assign mem_lock_s = sync2_q[19:18];
	assign ee_busy = sync2_q[20];
	assign ee_rise = ee_busy & ~ee_last_q;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// one wait state per access keeps read data registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign bus_take = ack_q & avs_write;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	assign ctrl_wr = bus_take && avs_address == `FSPS_OFS_CTRL && avs_byteenable[0];
	assign instr_wr = bus_take && avs_address == `FSPS_OFS_INSTR && avs_byteenable[0];

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	assign pat = avs_writedata[4:0];
	assign pat_ok = pat == `FSPS_PAT_LOAD || pat == `FSPS_PAT_ERASE ||
		pat == `FSPS_PAT_WRITE || pat == `FSPS_PAT_LOCK ||
		pat == `FSPS_PAT_REENABLE;
	assign armed = (store_win_q != 3'h0);
	assign store_instr = instr_wr & avs_writedata[`FSPS_BIT_STORE_INSTR];
	assign load_instr = instr_wr & ~avs_writedata[`FSPS_BIT_STORE_INSTR] &
		avs_writedata[`FSPS_BIT_LOAD_INSTR];
	// an eeprom write in flight swallows the instruction
	assign store_ok = store_instr & armed & ~ee_busy;
	assign load_ok = load_instr & armed & (load_win_q != 2'h0) &
		(sel_q == `FSPS_SEL_LOCK) & ~ee_busy;
	assign do_load = store_ok && sel_q == `FSPS_SEL_LOAD;
	assign do_erase = store_ok && sel_q == `FSPS_SEL_ERASE;
	assign do_write = store_ok && sel_q == `FSPS_SEL_WRITE;
	assign do_lock = store_ok && sel_q == `FSPS_SEL_LOCK;
	assign do_reenable = store_ok && sel_q == `FSPS_SEL_REENABLE;
	assign start_page = zptr_q[`FSPS_Z_PAGE_MSB:`FSPS_Z_PAGE_LSB];

	// ----------------------------------------
	// control register and arming window
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_en_q <= 1'b0;
			sel_q <= 4'h0;
			store_win_q <= 3'h0;
			load_win_q <= 2'h0;
		end else begin
			if (ctrl_wr) begin
				irq_en_q <= avs_writedata[`FSPS_BIT_IRQ_EN];
			end
			if (ctrl_wr && pat_ok && !op_busy && !armed && !ee_busy) begin
				sel_q <= avs_writedata[4:1];
				store_win_q <= `FSPS_STORE_WINDOW;
				if (avs_writedata[`FSPS_BIT_LOCK_SET]) begin
					load_win_q <= `FSPS_LOAD_WINDOW;
				end else begin
					load_win_q <= 2'h0;
				end
			end else if (store_ok || load_ok) begin
				sel_q <= 4'h0;
				store_win_q <= 3'h0;
				load_win_q <= 2'h0;
			end else begin
				if (store_win_q != 3'h0) begin
					store_win_q <= store_win_q - 3'h1;
				end
				if (store_win_q == 3'h1) begin
					sel_q <= 4'h0;
				end
				if (load_win_q != 2'h0) begin
					load_win_q <= load_win_q - 2'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// operand registers and load result
	// ----------------------------------------
	always @* begin
		if (zptr_q == `FSPS_Z_LOCK) begin
			lpm_value = lock_byte;
		end else if (zptr_q == `FSPS_Z_FUSE_HIGH) begin
			lpm_value = fuse_high_s;
		end else if (zptr_q == `FSPS_Z_FUSE_EXT) begin
			lpm_value = {6'h3F, fuse_ext_s};
		end else begin
			lpm_value = fuse_low_s;
		end
	end

	// stored bits keep their raw sense: a programmed bit is a zero
	assign lock_byte = {2'h3, boot_lock_q, mem_lock_s};

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			zptr_q <= 16'h0000;
			rdata_q <= 16'h0000;
			lpm_result_q <= 8'h00;
		end else begin
			if (bus_take && avs_address == `FSPS_OFS_ZPTR) begin
				if (avs_byteenable[0]) begin
					zptr_q[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					zptr_q[15:8] <= avs_writedata[15:8];
				end
			end
			if (bus_take && avs_address == `FSPS_OFS_RDATA) begin
				if (avs_byteenable[0]) begin
					rdata_q[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					rdata_q[15:8] <= avs_writedata[15:8];
				end
			end
			if (load_ok) begin
				lpm_result_q <= lpm_value;
			end
		end
	end

	// ----------------------------------------
	// programming operation state
	// ----------------------------------------
	// kept on power-on reset so a system reset cannot cut a write short
	always @(posedge clk or negedge por_b) begin
		if (!por_b) begin
			op_sel_q <= 4'h0;
			op_no_read_while_write_section_q <= 1'b0;
			flash_page_q <= 8'h00;
			flash_erase_start_q <= 1'b0;
			flash_write_start_q <= 1'b0;
			boot_lock_q <= `FSPS_RST_BOOT_LOCK;
		end else begin
			flash_erase_start_q <= do_erase;
			flash_write_start_q <= do_write;
			if (do_erase || do_write || do_lock) begin
				op_sel_q <= sel_q;
				op_no_read_while_write_section_q <= (start_page >= `FSPS_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
			end
			if (do_erase || do_write) begin
				flash_page_q <= start_page;
			end
			if (do_lock) begin
				boot_lock_q <= boot_lock_q & rdata_q[5:2];
			end
		end
	end

	fsps_op_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.clk(clk),
		.por_b(por_b),
		.start(do_erase | do_write | do_lock),
		.busy(op_busy),
		.done_q(op_done)
	);

	// halt only for the no_read_while_write_section section, lock programming leaves flash readable
	assign cpu_halt = op_busy & op_no_read_while_write_section_q & (op_sel_q != `FSPS_SEL_LOCK);

	// ----------------------------------------
	// read-while-write busy flag
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rw_busy_q <= 1'b0;
		end else if ((do_erase || do_write) && start_page < `FSPS_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) begin
			rw_busy_q <= 1'b1;
		end else if ((do_reenable && !op_busy) || do_load) begin
			rw_busy_q <= 1'b0;
		end
	end

	assign rw_section_read_block = rw_busy_q;

	// ----------------------------------------
	// temporary page buffer
	// ----------------------------------------
	// system reset clears the buffer once no write still needs it
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_clear_q <= 1'b1;
		end else if (!op_busy) begin
			reset_clear_q <= 1'b0;
		end
	end

	assign buf_clear = (reset_clear_q & ~op_busy) | do_reenable |
		(op_done & (op_sel_q == `FSPS_SEL_WRITE)) | (ee_rise & buf_any);

	fsps_page_buffer u_buf (
		.clk(clk),
		.por_b(por_b),
		.load(do_load),
		.load_addr(zptr_q[`FSPS_Z_WORD_MSB:`FSPS_Z_WORD_LSB]),
		.load_data(rdata_q),
		.clear(buf_clear),
		.any_loaded(buf_any),
		.rd_addr(array_rd_addr),
		.rd_data_q(array_rd_data)
	);

	// ----------------------------------------
	// status, interrupt and read data
	// ----------------------------------------
	assign store_en_rd = armed | op_busy;
	assign ctrl_rd = {irq_en_q, rw_busy_q, 1'b0,
		armed ? sel_q : (op_busy ? op_sel_q : 4'h0), store_en_rd};
	assign program_ready_irq = irq_en_q & ~store_en_rd;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !ack_q) begin
			if (avs_address == `FSPS_OFS_CTRL) begin
				avs_readdata <= {24'h000000, ctrl_rd};
			end else if (avs_address == `FSPS_OFS_ZPTR) begin
				avs_readdata <= {16'h0000, zptr_q};
			end else if (avs_address == `FSPS_OFS_RDATA) begin
				avs_readdata <= {16'h0000, rdata_q};
			end else if (avs_address == `FSPS_OFS_LPM) begin
				avs_readdata <= {24'h000000, lpm_result_q};
			end else begin
				avs_readdata <= 32'h00000000;
			end
		end
	end

endmodule

// ---- tb/fsps_checker.sv ----
// assertion checker bound to the flash self-program sequencer
`timescale 1ns/1ps
`include "fsps_defines.vh"
module fsps_checker #(
	parameter integer PROG_CYCLES = 20
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// bus and chip side
	input wire [4:0] avs_address,
	input wire avs_write,
	input wire eeprom_write_busy,
	// flash and cpu side
	input wire flash_erase_start_q,
	input wire flash_write_start_q,
	input wire [7:0] flash_page_q,
	input wire cpu_halt,
	input wire rw_section_read_block,
	input wire program_ready_irq
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	wire start = flash_erase_start_q | flash_write_start_q;
	wire no_read_while_write_section = flash_page_q >= `FSPS_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	irq_off_busy_a: assert property (start |-> !program_ready_irq)
		else $error("ready irq high while a program operation starts");
	erase_pulse_a: assert property (flash_erase_start_q |=> !flash_erase_start_q)
		else $error("erase start longer than one cycle");
	one_start_a: assert property (!(flash_erase_start_q && flash_write_start_q))
		else $error("erase and write started together");
	no_read_while_write_section_halt_a: assert property (start && no_read_while_write_section |-> cpu_halt)
		else $error("no halt for upper section operation");
	rww_block_a: assert property (start && !no_read_while_write_section |-> rw_section_read_block && !cpu_halt)
		else $error("lower section operation without read block or with halt");
	halt_hold_a: assert property ($rose(cpu_halt) |=> cpu_halt [*8])
		else $error("halt dropped early");
	ee_block_a: assert property (eeprom_write_busy [*5] |-> !start)
		else $error("programming started during eeprom write");
	reenable_fall_a: assert property ($fell(rw_section_read_block) |->
		$past(avs_write && avs_address == `FSPS_OFS_INSTR))
		else $error("read block cleared without a store");
	cover property (start && no_read_while_write_section);
	cover property (flash_write_start_q);
	cover property ($fell(rw_section_read_block));
endmodule
bind fsps_top fsps_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.clk(clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_write(avs_write), .eeprom_write_busy(eeprom_write_busy),
	.flash_erase_start_q(flash_erase_start_q), .flash_write_start_q(flash_write_start_q),
	.flash_page_q(flash_page_q), .cpu_halt(cpu_halt),
	.rw_section_read_block(rw_section_read_block), .program_ready_irq(program_ready_irq));

// ---- tb/fsps_cpu_model.sv ----
// cpu core model: avalon master issuing boot loader accesses
`timescale 1ns/1ps
module fsps_cpu_model (
	// clock
	input logic clk,
	// avalon master
	output logic [4:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [3:0] avs_byteenable,
	output logic [31:0] avs_writedata,
	input logic [31:0] avs_readdata,
	input logic avs_waitrequest
);
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0;
	end
	// request held until the rising edge that samples waitrequest low; data taken there
	task automatic xfer(input logic is_rd, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= !is_rd;
		avs_read <= is_rd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// ends off the edge so callers sample settled outputs
		@(negedge clk);
	endtask
endmodule

// ---- tb/tb_top.sv ----
// testbench for the flash self-program sequencer
`timescale 1ns/1ps
`include "fsps_defines.vh"
module tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic por_b = 1'b0;
	logic eeprom_write_busy = 1'b0;
	logic [6:0] array_rd_addr = 7'h00;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic flash_erase_start_q;
	logic flash_write_start_q;
	logic [7:0] flash_page_q;
	logic [15:0] array_rd_data;
	logic cpu_halt;
	logic rw_section_read_block;
	logic program_ready_irq;
	logic [31:0] q;
	int n_errors = 0;
	int checked = 0;
	int n_er = 0;
	int n_wr = 0;
	always #20 clk = ~clk;
	// ----------------------------------------
	// design and cpu model
	// ----------------------------------------
	fsps_top #(.PROG_CYCLES(20)) uut (.clk(clk), .rst_b(rst_b), .por_b(por_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.eeprom_write_busy(eeprom_write_busy), .fuse_low_byte(8'h5A), .fuse_high_byte(8'hC3),
		.fuse_extended_bits(2'h2), .memory_lock_bits(2'h1),
		.flash_erase_start_q(flash_erase_start_q), .flash_write_start_q(flash_write_start_q),
		.flash_page_q(flash_page_q), .array_rd_addr(array_rd_addr),
		.array_rd_data(array_rd_data), .cpu_halt(cpu_halt),
		.rw_section_read_block(rw_section_read_block), .program_ready_irq(program_ready_irq));
	fsps_cpu_model cpu (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	// start pulses counted off the edge, where they are settled
	always @(negedge clk) begin
		if (flash_erase_start_q === 1'b1) n_er++;
		if (flash_write_start_q === 1'b1) n_wr++;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] t;
		cpu.xfer(1'b0, a, d, t);
	endtask
	task automatic rd(input logic [4:0] a);
		cpu.xfer(1'b1, a, 32'h0, q);
	endtask
	task automatic spm(input logic [7:0] c, input logic [15:0] z, input logic [15:0] r);
		int n;
		wr(`FSPS_OFS_ZPTR, {16'h0, z});
		wr(`FSPS_OFS_RDATA, {16'h0, r});
		for (n = 0; n < 50 && eeprom_write_busy; n++) @(posedge clk);
		wr(`FSPS_OFS_CTRL, {24'h0, c});
		wr(`FSPS_OFS_INSTR, 32'h1);
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 60; n++) begin
			rd(`FSPS_OFS_CTRL);
			if (q[0] === 1'b0) break;
		end
	endtask
	task automatic arr(input logic [6:0] w, input logic [15:0] e);
		@(posedge clk);
		array_rd_addr <= w;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(array_rd_data, e);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_load;
		spm(8'h01, 16'h000A, 16'h1234);
		spm(8'h01, 16'h0004, 16'hABCD);
		spm(8'h01, 16'h000A, 16'h5555);
		arr(7'h05, 16'h1234);
		arr(7'h02, 16'hABCD);
		arr(7'h00, 16'hFFFF);
	endtask
	task automatic t_page;
		wr(`FSPS_OFS_CTRL, 32'h80);
		chk(program_ready_irq, 32'h1);
		spm(8'h83, 16'h1000, 16'h0);
		chk(rw_section_read_block, 32'h1);
		wait_idle;
		chk(n_er, 32'h1);
		spm(8'h85, 16'h1000, 16'h0);
		rd(`FSPS_OFS_CTRL);
		chk(q[7:0], 8'hC5);
		chk(program_ready_irq, 32'h0);
		wait_idle;
		chk(q[7:0], 8'hC0);
		chk(program_ready_irq, 32'h1);
		chk(n_wr, 32'h1);
		chk(flash_page_q, 8'h10);
		arr(7'h05, 16'hFFFF);
		spm(8'h91, 16'h0, 16'h0);
		chk(rw_section_read_block, 32'h0);
	endtask
	task automatic t_lock;
		logic [7:0] exp [4] = '{8'h5A, 8'hF1, 8'hFE, 8'hC3};
		spm(8'h09, 16'h0001, 16'h00F3);
		wait_idle;
		for (int i = 0; i < 4; i++) begin
			wr(`FSPS_OFS_ZPTR, i);
			wr(`FSPS_OFS_CTRL, 32'h09);
			wr(`FSPS_OFS_INSTR, 32'h2);
			rd(`FSPS_OFS_LPM);
			chk(q[7:0], exp[i]);
			rd(`FSPS_OFS_CTRL);
			chk(q[4:0], 5'h00);
		end
	endtask
	task automatic t_refuse;
		wr(`FSPS_OFS_CTRL, 32'h07);
		rd(`FSPS_OFS_CTRL);
		chk(q[7:0], 8'h00);
		wr(`FSPS_OFS_ZPTR, 32'h000E);
		wr(`FSPS_OFS_RDATA, 32'h7777);
		wr(`FSPS_OFS_CTRL, 32'h01);
		repeat (6) @(posedge clk);
		wr(`FSPS_OFS_INSTR, 32'h1);
		arr(7'h07, 16'hFFFF);
		spm(8'h01, 16'h0006, 16'h0F0F);
		arr(7'h03, 16'h0F0F);
		@(posedge clk);
		eeprom_write_busy <= 1'b1;
		repeat (4) @(posedge clk);
		arr(7'h03, 16'hFFFF);
		wr(`FSPS_OFS_CTRL, 32'h03);
		wr(`FSPS_OFS_INSTR, 32'h1);
		repeat (3) @(negedge clk);
		chk(n_er, 32'h1);
		@(posedge clk);
		eeprom_write_busy <= 1'b0;
	endtask
	task automatic t_no_read_while_write_section;
		spm(8'h01, 16'h0002, 16'h2222);
		spm(8'h03, 16'hE000, 16'h0);
		repeat (2) @(negedge clk);
		chk(cpu_halt, 32'h1);
		chk(rw_section_read_block, 32'h0);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk(cpu_halt, 32'h1);
		for (int n = 0; n < 100 && cpu_halt !== 1'b0; n++) @(negedge clk);
		chk(n_er, 32'h2);
		arr(7'h01, 16'hFFFF);
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		t_load;
		t_page;
		t_lock;
		t_refuse;
		t_no_read_while_write_section;
		end_of_test;
	end
	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		end_of_test;
	end
endmodule
